// File: rtl/fsic_pkg.sv
// fsic_pkg: shared constants and carriers for the four source interrupt controller
// assumes a single 10 MHz core clock and an 8-bit core that writes control bits
package fsic_pkg;
    // service vectors, word addresses in program memory
    localparam logic [11:0] FSIC_VEC_USB = 12'h0004;
    localparam logic [11:0] FSIC_VEC_EXT = 12'h0008;
    localparam logic [11:0] FSIC_VEC_TMR = 12'h000C;
    localparam logic [11:0] FSIC_VEC_SPI = 12'h0010;
    localparam logic [11:0] FSIC_VEC_NONE = 12'h0000;
    // source index, also priority order (0 is highest)
    localparam int FSIC_SRC_USB = 0;
    localparam int FSIC_SRC_EXT = 1;
    localparam int FSIC_SRC_TMR = 2;
    localparam int FSIC_SRC_SPI = 3;
    localparam int FSIC_NSRC = 4;
    // usb control/status and port a interrupt bit positions, flag and byte reset values
    localparam int FSIC_USC_SUSPEND = 0;
    localparam int FSIC_USC_RESUME = 3;
    localparam int FSIC_PORTA_INT_BIT = 6;
    localparam logic [3:0] FSIC_FLAGS_RST = 4'h0;
    localparam logic [7:0] FSIC_BYTE_RST = 8'h00;

    // software side: writes of enables and flags
    typedef struct packed {
        logic global_int_enable;
        logic [3:0] src_enable;     // usb, ext, timer, serial
        logic flag_wr;              // write strobe for flag image
        logic [3:0] flag_wdata;     // zeros clear, ones set
        logic gie_wr;
        logic gie_wdata;
    } fsic_sw_t;

    // grant toward the core sequencer
    typedef struct packed {
        logic take;
        logic [11:0] vector;
    } fsic_grant_t;
endpackage

// File: rtl/fsic_sync.sv
// fsic_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/1ps
module fsic_sync (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg, s2_reg, s3_reg, level_reg;
    // pins idle high (pull-high), so stages reset high to avoid a false fall
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level_reg <= 1'b1;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) level_reg <= s3_reg; // change counts on agreement
        end
    end
    assign level_o = level_reg;
endmodule

// File: rtl/fsic_flag.sv
// fsic_flag: one sticky request flag, hardware set beats any clear
// assumes set, clear and write pulses are on ref_clk_i
`timescale 1ns/1ps
module fsic_flag (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic svc_clr_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic flag_o
);
    logic flag_reg, flag_next;
    // sticky regardless of enable; a set in the clearing cycle wins
    assign flag_next = set_i ? 1'b1 :
                       svc_clr_i ? 1'b0 :
                       wr_i ? wdata_i : flag_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) flag_reg <= 1'b0;
        else flag_reg <= flag_next;
    end
    assign flag_o = flag_reg;
endmodule

// File: rtl/fsic_top.sv
// fsic_top: four source interrupt controller with fixed priority and vectors
// assumes the core sequencer gives phase_two_pulse and stack state on ref_clk_i
// Function
// - service enabled request on the later phase pulse
// - fixed priority usb, ext, timer, serial
// - global enable zero suppresses all servicing
// - falling pin edge sets external flag
// - pin is interrupt input when enabled and input
// - external service vectors 08h, clears flag, global
// - pull-high option stays on in interrupt use
// - timer overflow sets timer flag
// - timer service vectors 0ch, clears flag, global
// - byte transferred sets serial flag
// - serial service vectors 10h, clears flag, global
// - four usb events set usb flag
// - usb service vectors 04h, clears flag, global
// - fifo access sets endpoint bit, software clears
// - suspend sets bit0, resume sets bit3
// - flags sticky until serviced or written zero
// - full stack withholds vectoring, keeps pending
// - any source wakes core from power-down
// - only program counter pushed on service
// - software may re-enable global for nesting
// - reset clears all enables and flags
`timescale 1ns/1ps
module fsic_top
    import fsic_pkg::*;
#(
    parameter int ENDPOINTS = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic phase_two_pulse_i,
    input wire fsic_pkg::fsic_sw_t sw_i,
    input wire logic stack_full_i,
    input wire logic powered_down_i,
    input wire logic port_a_bit_six_pin_i,
    input wire logic port_a_direction_bit6_i,
    input wire logic pull_high_option_i,
    input wire logic timer_overflow_i,
    input wire logic serial_byte_done_i,
    input wire logic [ENDPOINTS-1:0] fifo_access_i,
    input wire logic usb_suspend_i,
    input wire logic usb_resume_i,
    input wire logic usb_bus_reset_i,
    input wire logic [ENDPOINTS-1:0] endpoint_clr_i,
    input wire logic usb_cs_clr_wr_i,
    input wire logic [7:0] usb_cs_wdata_i,
    output fsic_pkg::fsic_grant_t grant_o,
    output logic push_pc_o,
    output logic wake_o,
    output logic global_int_enable_o,
    output logic [3:0] int_flags_o,
    output logic [ENDPOINTS-1:0] endpoint_access_flags_o,
    output logic [7:0] usb_control_status_o,
    output logic port_a_pull_high_o
);
    import fsic_pkg::*;

    // endpoint count must fit one usb flag per endpoint and at least one
    initial begin
        if (ENDPOINTS < 1 || ENDPOINTS > 8) begin
            $error("fsic_top: ENDPOINTS out of range");
        end
    end

    logic gie_reg, gie_next;
    logic [3:0] en_reg;
    logic [3:0] flags;
    logic [3:0] flag_set;
    logic [3:0] svc_clr;
    logic pin_level, pin_prev_reg;
    logic pin_fall;
    logic ext_pin_active;
    logic [3:0] pending;
    logic window_req_reg;
    logic [3:0] pick;
    logic take;
    logic [11:0] vec_sel;
    fsic_grant_t grant_reg;
    logic push_reg, wake_reg, pull_reg;
    logic [ENDPOINTS-1:0] ep_reg;
    logic [7:0] usc_reg;
    logic usb_event;

    // pin synchroniser; filtered level only is used downstream
    fsic_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(port_a_bit_six_pin_i),
        .level_o(pin_level)
    );

    // shared pin gating
    // pin acts as interrupt input only when enabled and direction is input
    assign ext_pin_active = en_reg[FSIC_SRC_EXT] & port_a_direction_bit6_i;
    assign pin_fall = pin_prev_reg & ~pin_level & ext_pin_active;

    assign usb_event = (|fifo_access_i) | usb_suspend_i | usb_resume_i | usb_bus_reset_i;

    assign flag_set[FSIC_SRC_USB] = usb_event;
    assign flag_set[FSIC_SRC_EXT] = pin_fall;
    assign flag_set[FSIC_SRC_TMR] = timer_overflow_i;
    assign flag_set[FSIC_SRC_SPI] = serial_byte_done_i;

    // sticky request flags
    // one flag cell per source
    for (genvar g = 0; g < FSIC_NSRC; g++) begin : g_flag
        fsic_flag u_flag (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .set_i(flag_set[g]),
            .svc_clr_i(svc_clr[g]),
            .wr_i(sw_i.flag_wr),
            .wdata_i(sw_i.flag_wdata[g]),
            .flag_o(flags[g])
        );
    end

    assign pending = flags & en_reg & {FSIC_NSRC{gie_reg}};

    // fixed priority pick, one winner only
    assign pick[FSIC_SRC_USB] = pending[FSIC_SRC_USB];
    assign pick[FSIC_SRC_EXT] = pending[FSIC_SRC_EXT] & ~pending[FSIC_SRC_USB];
    assign pick[FSIC_SRC_TMR] = pending[FSIC_SRC_TMR] & ~(|pending[1:0]);
    assign pick[FSIC_SRC_SPI] = pending[FSIC_SRC_SPI] & ~(|pending[2:0]);

    assign vec_sel = pick[FSIC_SRC_USB] ? FSIC_VEC_USB :
                     pick[FSIC_SRC_EXT] ? FSIC_VEC_EXT :
                     pick[FSIC_SRC_TMR] ? FSIC_VEC_TMR :
                     pick[FSIC_SRC_SPI] ? FSIC_VEC_SPI : FSIC_VEC_NONE;

    // service on phase pulse when a request was seen and stack has room
    // the window latch records a request seen since the last pulse
    assign take = phase_two_pulse_i & (window_req_reg | (|pending)) & (|pending) & ~stack_full_i;
    // service clears the winning flag only
    assign svc_clr = take ? pick : 4'h0;

    // global enable: service clears, software may set again
    assign gie_next = take ? 1'b0 :
                      sw_i.gie_wr ? sw_i.gie_wdata : gie_reg;

    // enables and global cleared at reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gie_reg <= 1'b0;
            en_reg <= FSIC_FLAGS_RST;
        end else begin
            gie_reg <= gie_next;
            en_reg <= sw_i.src_enable;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) window_req_reg <= 1'b0;
        else if (phase_two_pulse_i) window_req_reg <= 1'b0;
        else if (|pending) window_req_reg <= 1'b1;
    end

    // pin history for edge detect
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) pin_prev_reg <= 1'b1;
        else pin_prev_reg <= pin_level;
    end

    // endpoint access bits; access beats software clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ep_reg <= '0;
        else ep_reg <= fifo_access_i | (ep_reg & ~endpoint_clr_i);
    end

    // suspend and resume status bits, set wins over software clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            usc_reg <= FSIC_BYTE_RST;
        end else begin
            if (usb_cs_clr_wr_i) usc_reg <= usb_cs_wdata_i;
            if (usb_suspend_i) usc_reg[FSIC_USC_SUSPEND] <= 1'b1;
            if (usb_resume_i) usc_reg[FSIC_USC_RESUME] <= 1'b1;
        end
    end

    // registered outputs toward the core
    // a take asks only for the program counter push; acc and status stay with software
    // wake on any raised flag while powered down, regardless of enables
    // pull-high option passed through unchanged in interrupt use
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_reg <= '0;
            push_reg <= 1'b0;
            wake_reg <= 1'b0;
            pull_reg <= 1'b0;
        end else begin
            grant_reg.take <= take;
            grant_reg.vector <= take ? vec_sel : FSIC_VEC_NONE;
            push_reg <= take;
            wake_reg <= powered_down_i & ((|flag_set) | (|flags));
            pull_reg <= pull_high_option_i;
        end
    end

    assign grant_o = grant_reg;
    assign push_pc_o = push_reg;
    assign wake_o = wake_reg;
    assign port_a_pull_high_o = pull_reg;
    assign global_int_enable_o = gie_reg;
    assign int_flags_o = flags;
    assign endpoint_access_flags_o = ep_reg;
    assign usb_control_status_o = usc_reg;
endmodule

// File: sim/fsic_core_model.sv
// fsic_core_model: core sequencer side, source of the phase pulse
// assumes one core cycle, from one phase pulse to the next, spans four ref_clk_i cycles
`timescale 1ns/1ps
module fsic_core_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    output logic phase_two_pulse_o
);
    logic [1:0] ph_reg;
    // free-running phase count, one pulse in four cycles
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ph_reg <= 2'h0;
        else ph_reg <= ph_reg + 2'h1;
    end
    assign phase_two_pulse_o = (ph_reg == 2'h3);
endmodule

// File: sim/fsic_top_props.sv
// fsic_props: timing checks on the controller's ports
// assumes bound into fsic_top, one clock domain
`timescale 1ns/1ps
module fsic_props
    import fsic_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic phase_two_pulse_i,
    input wire fsic_pkg::fsic_sw_t sw_i,
    input wire logic stack_full_i,
    input wire logic powered_down_i,
    input wire logic timer_overflow_i,
    input wire fsic_pkg::fsic_grant_t grant_o,
    input wire logic push_pc_o,
    input wire logic wake_o,
    input wire logic global_int_enable_o,
    input wire logic [3:0] int_flags_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // pending set, enables held stable by the bench
    wire [3:0] pend = int_flags_o & sw_i.src_enable;
    take_on_pulse_a: assert property (phase_two_pulse_i && !stack_full_i && global_int_enable_o
        && (pend != 4'h0) && $stable(sw_i.src_enable) |=> grant_o.take) else $error("no take");
    gie_gates_a: assert property (grant_o.take |-> $past(global_int_enable_o)) else $error("gie");
    stack_hold_a: assert property (grant_o.take |-> !$past(stack_full_i)) else $error("stack");
    prio_vector_a: assert property (grant_o.take |-> grant_o.vector == ($past(pend[0]) ?
        FSIC_VEC_USB : $past(pend[1]) ? FSIC_VEC_EXT : $past(pend[2]) ? FSIC_VEC_TMR :
        FSIC_VEC_SPI)) else $error("vector");
    gie_clear_a: assert property (grant_o.take |-> !global_int_enable_o) else $error("clr");
    single_take_a: assert property (grant_o.take |=> !grant_o.take) else $error("twice");
    pc_push_a: assert property (push_pc_o == grant_o.take) else $error("push");
    timer_flag_a: assert property (timer_overflow_i |=> int_flags_o[2]) else $error("tf");
    wake_any_a: assert property (powered_down_i && int_flags_o != 4'h0 |=> wake_o)
        else $error("wake");
    flag_sticky_a: assert property ($fell(int_flags_o[2]) |-> grant_o.take
        || $past(sw_i.flag_wr)) else $error("sticky");
endmodule
bind fsic_top fsic_props u_props (.ref_clk_i, .rst_n_i, .phase_two_pulse_i, .sw_i,
    .stack_full_i, .powered_down_i, .timer_overflow_i, .grant_o, .push_pc_o, .wake_o,
    .global_int_enable_o, .int_flags_o);

// File: sim/fsic_top_bench.sv
// fsic_top_bench: scenario tasks for the interrupt controller
// assumes fsic_core_model supplies the phase pulse
`timescale 1ns/1ps
module fsic_top_bench;
    import fsic_pkg::*;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, stack_full_i = 1'b0, powered_down_i = 1'b0;
    logic port_a_bit_six_pin_i = 1'b1, port_a_direction_bit6_i = 1'b1, pull_high_option_i = 1'b0;
    logic timer_overflow_i = 1'b0, serial_byte_done_i = 1'b0, usb_suspend_i = 1'b0;
    logic usb_resume_i = 1'b0, usb_bus_reset_i = 1'b0, usb_cs_clr_wr_i = 1'b0;
    logic [3:0] fifo_access_i = 4'h0, endpoint_clr_i = 4'h0;
    logic [7:0] usb_cs_wdata_i = 8'h00;
    fsic_sw_t sw_i = '{src_enable: 4'hf, default: '0};
    logic phase_two_pulse_i, push_pc_o, wake_o, global_int_enable_o, port_a_pull_high_o;
    logic [3:0] int_flags_o, endpoint_access_flags_o;
    logic [7:0] usb_control_status_o;
    fsic_grant_t grant_o;
    int n_mismatch = 0, n_checks = 0;
    fsic_core_model core (.ref_clk_i, .rst_n_i, .phase_two_pulse_o(phase_two_pulse_i));
    fsic_top dut (.ref_clk_i, .rst_n_i, .phase_two_pulse_i, .sw_i, .stack_full_i,
        .powered_down_i, .port_a_bit_six_pin_i, .port_a_direction_bit6_i, .pull_high_option_i,
        .timer_overflow_i, .serial_byte_done_i, .fifo_access_i, .usb_suspend_i, .usb_resume_i,
        .usb_bus_reset_i, .endpoint_clr_i, .usb_cs_clr_wr_i, .usb_cs_wdata_i, .grant_o,
        .push_pc_o, .wake_o, .global_int_enable_o, .int_flags_o, .endpoint_access_flags_o,
        .usb_control_status_o, .port_a_pull_high_o);
    // 100 ns clock
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // inputs always move 10 ns after the edge, away from sampling
    task automatic tick(int n = 1);
        repeat (n) @(posedge ref_clk_i);
        #10;
    endtask
    task automatic gie_on();
        sw_i.gie_wr = 1'b1;
        sw_i.gie_wdata = 1'b1;
        tick();
        sw_i.gie_wr = 1'b0;
    endtask
    // bounded wait for a grant; fff means none came
    task automatic wait_take(output logic [11:0] v);
        v = 12'hfff;
        for (int i = 0; i < 12 && v === 12'hfff; i++) begin
            tick();
            if (grant_o.take === 1'b1) v = grant_o.vector;
        end
    endtask
    task automatic t_timer();
        logic [11:0] v;
        gie_on();
        timer_overflow_i = 1'b1;
        tick();
        timer_overflow_i = 1'b0;
        chk("tflag", 16'h0004, int_flags_o);
        wait_take(v);
        chk("tvec", 16'h000c, v);
        chk("tclr", 16'h0000, {global_int_enable_o, int_flags_o});
    endtask
    task automatic t_prio();
        logic [11:0] v;
        logic [11:0] exp_v[4] = '{FSIC_VEC_USB, FSIC_VEC_EXT, FSIC_VEC_TMR, FSIC_VEC_SPI};
        {usb_suspend_i, timer_overflow_i, serial_byte_done_i, port_a_bit_six_pin_i} = 4'he;
        tick();
        {usb_suspend_i, timer_overflow_i, serial_byte_done_i} = 3'h0;
        tick(8);
        chk("flags", 16'h000f, int_flags_o);
        chk("usc", 16'h0001, usb_control_status_o);
        wait_take(v);
        chk("masked", 16'h0fff, v);
        for (int i = 0; i < 4; i++) begin
            gie_on();
            wait_take(v);
            chk("pvec", exp_v[i], v);
            chk("left", (4'hf << (i + 1)) & 4'hf, int_flags_o);
        end
        port_a_bit_six_pin_i = 1'b1;
    endtask
    task automatic t_stack();
        logic [11:0] v;
        stack_full_i = 1'b1;
        timer_overflow_i = 1'b1;
        tick();
        timer_overflow_i = 1'b0;
        gie_on();
        wait_take(v);
        chk("full", 16'h0fff, v);
        stack_full_i = 1'b0;
        wait_take(v);
        chk("freed", 16'h000c, v);
    endtask
    task automatic t_usb();
        {usb_resume_i, fifo_access_i} = 5'h12;
        tick();
        {usb_resume_i, fifo_access_i} = 5'h00;
        tick();
        chk("usc", 16'h0009, usb_control_status_o);
        chk("ep", 16'h0012, {int_flags_o, endpoint_access_flags_o});
        endpoint_clr_i = 4'h2;
        usb_cs_clr_wr_i = 1'b1;
        sw_i.flag_wr = 1'b1;
        tick();
        {endpoint_clr_i, usb_cs_clr_wr_i, sw_i.flag_wr} = 6'h00;
        tick();
        chk("usbclr", 16'h0000, {int_flags_o, endpoint_access_flags_o, usb_control_status_o});
    endtask
    task automatic t_wake();
        powered_down_i = 1'b1;
        serial_byte_done_i = 1'b1;
        pull_high_option_i = 1'b1;
        tick();
        serial_byte_done_i = 1'b0;
        tick(2);
        chk("wake", 16'h0003, {wake_o, port_a_pull_high_o});
    endtask
    // pin set up as output: a falling level must not raise the external flag
    task automatic t_pin();
        port_a_direction_bit6_i = 1'b0;
        port_a_bit_six_pin_i = 1'b0;
        tick(8);
        chk("nodir", 16'h0000, int_flags_o & 4'h2);
        port_a_bit_six_pin_i = 1'b1;
        tick(8);
        port_a_direction_bit6_i = 1'b1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        tick(5);
        chk("rst", 16'h0000, {global_int_enable_o, int_flags_o, wake_o, grant_o.take});
        rst_n_i = 1'b1;
        t_timer();
        t_prio();
        t_stack();
        t_usb();
        t_wake();
        t_pin();
        stop_test();
    end
    // watchdog, run needs about a hundred cycles
    initial begin
        #300000;
        n_mismatch++;
        stop_test();
    end
endmodule
